// file: rtl/ise_pkg.sv
// Constants and carrier types for the set-enable and set-active register banks.
package ise_pkg;

  localparam int unsigned REG_W        = 32;
  localparam int unsigned NUM_REGS     = 32;
  localparam int unsigned NUM_PE_BANKS = 8;
  localparam int unsigned NUM_IDS      = REG_W * NUM_REGS;
  localparam int unsigned EXT_ID_BASE  = 4096;
  localparam int unsigned SGI_COUNT    = 16;
  localparam int unsigned IDX_W        = 5;
  localparam int unsigned IDX_LSB      = 2;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned PE_W         = 4;

  localparam logic [ADDR_W-1:0] OFS_EN_SET      = 16'h0100;
  localparam logic [ADDR_W-1:0] OFS_EXT_EN_SET  = 16'h1200;
  localparam logic [ADDR_W-1:0] OFS_EXT_ACT_SET = 16'h1a00;
  localparam logic [ADDR_W-1:0] BANK_SPAN       = 16'h0080;

  typedef enum logic [1:0] {
    ISE_BK_NONE,
    ISE_BK_EN,
    ISE_BK_EXT_EN,
    ISE_BK_EXT_ACT
  } ise_bank_t;

  typedef struct packed {
    logic              req;
    logic              wr;
    logic              ns;
    logic [PE_W-1:0]   pe;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } ise_req_t;

  typedef struct packed {
    logic             security_disable;
    logic             are_secure;
    logic             are_nonsecure;
    logic             extended_range_supported;
    logic [IDX_W-1:0] interrupt_lines_field;
    logic [IDX_W-1:0] extended_range_size;
  } ise_cfg_t;

  typedef struct packed {
    logic [NUM_PE_BANKS-1:0][REG_W-1:0] en0;
    logic [NUM_REGS-1:1][REG_W-1:0]     en;
    logic [NUM_REGS-1:0][REG_W-1:0]     ext_en;
    logic [NUM_REGS-1:0][REG_W-1:0]     ext_act;
    logic [REG_W-1:0]                   rdata;
    logic                               ack;
  } ise_state_t;

endpackage

// file: rtl/ise_set_banks.sv
// Write-one-to-set enable and active banks of the interrupt distributor.
//
// Overview of operation
// - Writing one to an extended set-active bit makes that interrupt active.
// - Extended set-active read returns one when the interrupt is active.
// - Zero bits in a set write leave the interrupt state unchanged.
// - After a set write the bit reads one until something clears it.
// - Warm reset clears all extended enable and active bits.
// - Normal-range enable bits have no defined reset value for software.
// - Extended identifier m maps to index (m-4096)/32, bit (m-4096)%32.
// - Normal identifier m maps to index m/32, bit m%32.
// - Extended set-active words sit at 0x1A00 plus four times index.
// - Normal set-enable words sit at 0x100 plus four times index.
// - Extended set-enable words sit at 0x1200 plus four times index.
// - Implemented register count is the sizing field plus one.
// - Extended banks read zero and ignore writes when unsupported.
// - Extended bit is reserved-zero when affinity routing is off for it.
// - Without security disable, secure extended bits are hidden from non-secure.
// - Without security disable, secure normal enable bits are hidden from non-secure.
// - Bits of unimplemented identifiers read zero and ignore writes.
// - With affinity routing, private and software interrupt enables are reserved-zero.
// - Software interrupts are either always enabled or writable, by parameter.
// - Enable word zero is banked per processor below eight, else hidden.
// - Each enable bit gates forwarding of its interrupt; reads show it.
`timescale 1ns/10ps
module ise_set_banks #(
  parameter bit SGI_ALWAYS_ON = 1'b0                                  // Software interrupts fixed enabled
) (
  input  wire logic                                         i_mclk,           // 40 MHz clock
  input  wire logic                                         i_rst_n,          // Async warm reset, low
  input  wire ise_pkg::ise_req_t                            i_req,            // Register access request
  input  wire ise_pkg::ise_cfg_t                            i_cfg,            // Control and type fields
  input  wire logic [ise_pkg::NUM_IDS-1:0]                  i_grp_secure,     // Normal ids secure group
  input  wire logic [ise_pkg::NUM_IDS-1:0]                  i_ext_grp_secure, // Extended ids secure
  input  wire logic [ise_pkg::NUM_IDS-1:0]                  i_en_clr,         // Enable clear pulses
  input  wire logic [ise_pkg::PE_W-1:0]                     i_clr_pe,         // Bank for word 0 clears
  input  wire logic [ise_pkg::NUM_IDS-1:0]                  i_ext_en_clr,     // Ext enable clears
  input  wire logic [ise_pkg::NUM_IDS-1:0]                  i_ext_act_clr,    // Ext active clears
  output logic      [ise_pkg::REG_W-1:0]                    o_rdata,          // Read data
  output logic                                              o_ack,            // Access done pulse
  output logic      [ise_pkg::NUM_PE_BANKS*ise_pkg::REG_W-1:0] o_fwd_en0,     // Per-PE ids 0..31
  output logic      [ise_pkg::NUM_IDS-ise_pkg::REG_W-1:0]   o_fwd_en,         // Ids 32 upward
  output logic      [ise_pkg::NUM_IDS-1:0]                  o_ext_en,         // Extended enables
  output logic      [ise_pkg::NUM_IDS-1:0]                  o_ext_act         // Extended active
);

  logic [1:0]                      rst_sync_r;
  logic                            rst_n_q;
  ise_pkg::ise_state_t             st_r;
  ise_pkg::ise_state_t             st_nxt;
  ise_pkg::ise_bank_t              bank;
  logic [ise_pkg::IDX_W-1:0]       idx;
  logic [ise_pkg::REG_W-1:0]       sec_word;
  logic [ise_pkg::REG_W-1:0]       mask;
  logic [ise_pkg::REG_W-1:0]       sgi_mask;
  logic [ise_pkg::PE_W-1:0]        pe_sel;

  function automatic ise_pkg::ise_bank_t bank_of(input logic [ise_pkg::ADDR_W-1:0] a);
    ise_pkg::ise_bank_t b;
    b = ise_pkg::ISE_BK_NONE;
    if (a >= ise_pkg::OFS_EN_SET && a < ise_pkg::OFS_EN_SET + ise_pkg::BANK_SPAN) begin
      b = ise_pkg::ISE_BK_EN;
    end else if (a >= ise_pkg::OFS_EXT_EN_SET && a < ise_pkg::OFS_EXT_EN_SET + ise_pkg::BANK_SPAN) begin
      b = ise_pkg::ISE_BK_EXT_EN;
    end else if (a >= ise_pkg::OFS_EXT_ACT_SET && a < ise_pkg::OFS_EXT_ACT_SET + ise_pkg::BANK_SPAN) begin
      b = ise_pkg::ISE_BK_EXT_ACT;
    end
    return b;
  endfunction

  // Bits that this access may see and change; everything else is read-as-zero, write-ignored.
  function automatic logic [ise_pkg::REG_W-1:0] access_mask(
    input ise_pkg::ise_bank_t             b,
    input logic [ise_pkg::IDX_W-1:0]      ix,
    input logic                           ns,
    input logic [ise_pkg::PE_W-1:0]       pe,
    input ise_pkg::ise_cfg_t              cfg,
    input logic [ise_pkg::REG_W-1:0]      sec
  );
    logic [ise_pkg::REG_W-1:0] m;
    logic                      are_b;
    m = '1;
    if (b == ise_pkg::ISE_BK_NONE) begin
      m = '0;
    end else if (b == ise_pkg::ISE_BK_EN) begin
      if (ix > cfg.interrupt_lines_field) begin
        m = '0;
      end
      if (ix == '0 && pe >= ise_pkg::PE_W'(ise_pkg::NUM_PE_BANKS)) begin
        m = '0;
      end
    end else if (!cfg.extended_range_supported || ix > cfg.extended_range_size) begin
      m = '0;
    end
    for (int unsigned k = 0; k < ise_pkg::REG_W; k++) begin
      are_b = sec[k] ? cfg.are_secure : cfg.are_nonsecure;
      if (b != ise_pkg::ISE_BK_EN && !are_b) begin
        m[k] = 1'b0;
      end
      if (b == ise_pkg::ISE_BK_EN && ix == '0 && are_b) begin
        m[k] = 1'b0;
      end
      if (!cfg.security_disable && ns && sec[k]) begin
        m[k] = 1'b0;
      end
    end
    return m;
  endfunction

  // Release of the warm reset is synchronised; assertion stays asynchronous.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_q = rst_sync_r[1];

  assign bank     = bank_of(i_req.addr);
  assign idx      = i_req.addr[ise_pkg::IDX_LSB +: ise_pkg::IDX_W];
  assign sec_word = (bank == ise_pkg::ISE_BK_EN) ? i_grp_secure[{idx, 5'h00} +: ise_pkg::REG_W]
                                                 : i_ext_grp_secure[{idx, 5'h00} +: ise_pkg::REG_W];
  assign mask     = access_mask(bank, idx, i_req.ns, i_req.pe, i_cfg, sec_word);
  assign sgi_mask = SGI_ALWAYS_ON ? ise_pkg::REG_W'({ise_pkg::SGI_COUNT{1'b1}}) : '0;
  assign pe_sel   = i_req.pe;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = i_req.req;
    st_nxt.rdata = '0;
    // Clears are applied first so that a set in the same cycle wins.
    for (int unsigned p = 0; p < ise_pkg::NUM_PE_BANKS; p++) begin
      if (i_clr_pe == ise_pkg::PE_W'(p)) begin
        st_nxt.en0[p] = st_r.en0[p] & ~i_en_clr[ise_pkg::REG_W-1:0];
      end
    end
    for (int unsigned r = 1; r < ise_pkg::NUM_REGS; r++) begin
      st_nxt.en[r] = st_r.en[r] & ~i_en_clr[r*ise_pkg::REG_W +: ise_pkg::REG_W];
    end
    for (int unsigned r = 0; r < ise_pkg::NUM_REGS; r++) begin
      st_nxt.ext_en[r]  = st_r.ext_en[r] & ~i_ext_en_clr[r*ise_pkg::REG_W +: ise_pkg::REG_W];
      st_nxt.ext_act[r] = st_r.ext_act[r] & ~i_ext_act_clr[r*ise_pkg::REG_W +: ise_pkg::REG_W];
    end
    if (i_req.req) begin
      case (bank)
        ise_pkg::ISE_BK_EN: begin
          if (idx == '0) begin
            if (i_req.wr) begin
              st_nxt.en0[pe_sel[2:0]] = st_nxt.en0[pe_sel[2:0]] | (i_req.wdata & mask & ~sgi_mask);
            end else begin
              st_nxt.rdata = (st_r.en0[pe_sel[2:0]] | sgi_mask) & mask;
            end
          end else if (i_req.wr) begin
            st_nxt.en[idx] = st_nxt.en[idx] | (i_req.wdata & mask);
          end else begin
            st_nxt.rdata = st_r.en[idx] & mask;
          end
        end
        ise_pkg::ISE_BK_EXT_EN: begin
          if (i_req.wr) begin
            st_nxt.ext_en[idx] = st_nxt.ext_en[idx] | (i_req.wdata & mask);
          end else begin
            st_nxt.rdata = st_r.ext_en[idx] & mask;
          end
        end
        ise_pkg::ISE_BK_EXT_ACT: begin
          if (i_req.wr) begin
            // An already active bit ORs to itself, so the write has no effect on it.
            st_nxt.ext_act[idx] = st_nxt.ext_act[idx] | (i_req.wdata & mask);
          end else begin
            st_nxt.rdata = st_r.ext_act[idx] & mask;
          end
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
    if (SGI_ALWAYS_ON) begin
      for (int unsigned p = 0; p < ise_pkg::NUM_PE_BANKS; p++) begin
        st_nxt.en0[p] = st_nxt.en0[p] | sgi_mask;
      end
    end
  end

  // Normal-range enables are cleared too; software still must not rely on it.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata   = st_r.rdata;
  assign o_ack     = st_r.ack;
  assign o_fwd_en0 = st_r.en0;
  assign o_fwd_en  = st_r.en;
  assign o_ext_en  = st_r.ext_en;
  assign o_ext_act = st_r.ext_act;

endmodule

// file: sim/ise_set_banks_sva.sv
// Checker for the set-enable and set-active register banks.
`timescale 1ns/10ps
module ise_set_banks_sva (
  input wire logic              i_mclk,        // Clock
  input wire logic              i_rst_n,       // Warm reset
  input wire ise_pkg::ise_req_t i_req,         // Access
  input wire ise_pkg::ise_cfg_t i_cfg,         // Config
  input wire logic [1023:0]     i_en_clr,      // Enable clears
  input wire logic [1023:0]     i_ext_en_clr,  // Ext enable clears
  input wire logic [1023:0]     i_ext_act_clr, // Ext active clears
  input wire logic [31:0]       o_rdata,       // Read data
  input wire logic              o_ack,         // Done
  input wire logic [255:0]      o_fwd_en0,     // Word 0 banks
  input wire logic [1023:0]     o_ext_en,      // Ext enables
  input wire logic [1023:0]     o_ext_act      // Ext active
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  ack_after_req_a: assert property (i_req.req |=> o_ack) else $error("no ack");
  rdata_idle_a: assert property (!o_ack |-> o_rdata == '0) else $error("rdata not zero");
  act_sticky_a: assert property (i_ext_act_clr == '0 |=> (o_ext_act & $past(o_ext_act)) == $past(o_ext_act))
    else $error("active lost");
  en_sticky_a: assert property (i_ext_en_clr == '0 |=> (o_ext_en & $past(o_ext_en)) == $past(o_ext_en))
    else $error("enable lost");
  ext_off_set_a: assert property (!i_cfg.extended_range_supported |=>
    (o_ext_act & ~$past(o_ext_act)) == '0 && (o_ext_en & ~$past(o_ext_en)) == '0) else $error("ext set");
  ext_off_read_a: assert property (i_req.req && !i_req.wr && !i_cfg.extended_range_supported && i_req.addr[12]
    |=> o_rdata == '0) else $error("ext read");
  clear_acts_a: assert property (!i_req.req |=> (o_ext_act & $past(i_ext_act_clr)) == '0)
    else $error("clear lost");
  high_pe_wi_a: assert property (i_req.req && i_req.wr && i_req.pe > 4'h7 && i_req.addr[15:2] == 14'h0040
    && i_en_clr == '0 |=> (o_fwd_en0 & ~$past(o_fwd_en0)) == '0) else $error("pe above 7 wrote");
endmodule

// file: sim/ise_pe_model.sv
// Processing element model that issues register accesses.
`timescale 1ns/10ps
module ise_pe_model (
  input  wire logic         i_mclk,  // Clock
  input  wire logic         i_ack,   // Done
  input  wire logic [31:0]  i_rdata, // Read data
  output ise_pkg::ise_req_t o_req    // Access
);
  initial o_req = '0;
  // Idle fields show the inverse of the last access, so stale values never pass as valid.
  // The ext_en and normal scenarios probe with non-secure accesses before secure ones.
  task automatic acc(input logic w, ns, input logic [3:0] pe, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(negedge i_mclk) o_req <= '{1'b1, w, ns, pe, a, d};
    @(negedge i_mclk) o_req <= '{1'b0, ~w, ~ns, ~pe, ~a, ~d};
    rd = (i_ack === 1'b1) ? i_rdata : 32'hdead_beef;
  endtask
endmodule

// file: sim/tb_ise_set_banks.sv
// Top testbench for the set-enable and set-active banks.
`timescale 1ns/10ps
module tb_ise_set_banks;
  logic              i_mclk = 1'b0;
  logic              i_rst_n = 1'b0;
  ise_pkg::ise_req_t i_req;
  ise_pkg::ise_cfg_t i_cfg = '{1'b1, 1'b1, 1'b1, 1'b1, 5'h01, 5'h00};
  logic [1023:0]     i_ext_act_clr = '0;
  logic [31:0]       o_rdata, rd;
  logic              o_ack;
  logic [255:0]      o_fwd_en0;
  logic [991:0]      o_fwd_en;
  logic [1023:0]     o_ext_en, o_ext_act;
  int                fail_count = 0;
  int                checked = 0;
  initial forever #12.5 i_mclk = ~i_mclk;
  ise_pe_model u_ise_pe_model (.i_mclk(i_mclk), .i_ack(o_ack), .i_rdata(o_rdata), .o_req(i_req));
  ise_set_banks u_ise_set_banks (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req), .i_cfg(i_cfg),
    .i_grp_secure(1024'h2 << 32), .i_ext_grp_secure(1024'h2), .i_en_clr('0), .i_clr_pe(4'h0),
    .i_ext_en_clr('0), .i_ext_act_clr(i_ext_act_clr), .o_rdata(o_rdata), .o_ack(o_ack),
    .o_fwd_en0(o_fwd_en0), .o_fwd_en(o_fwd_en), .o_ext_en(o_ext_en), .o_ext_act(o_ext_act));
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic ns, input logic [3:0] pe, input logic [15:0] a, input logic [31:0] d);
    u_ise_pe_model.acc(1'b1, ns, pe, a, d, rd);
  endtask
  task automatic rdc(input logic ns, input logic [3:0] pe, input logic [15:0] a, input logic [31:0] exp);
    u_ise_pe_model.acc(1'b0, ns, pe, a, 32'h0, rd);
    chk(rd, exp);
  endtask
  task automatic t_ext_act;
    wr(1'b0, 4'h0, 16'h1a00, 32'h0000_00a5);
    rdc(1'b0, 4'h0, 16'h1a00, 32'h0000_00a5);
    wr(1'b0, 4'h0, 16'h1a00, 32'h0000_0000);
    chk(o_ext_act[31:0], 32'h0000_00a5);
    wr(1'b0, 4'h0, 16'h1a04, 32'hffff_ffff);
    rdc(1'b0, 4'h0, 16'h1a04, 32'h0);
    @(negedge i_mclk) i_ext_act_clr[0] <= 1'b1;
    @(negedge i_mclk) i_ext_act_clr[0] <= 1'b0;
    rdc(1'b0, 4'h0, 16'h1a00, 32'h0000_00a4);
    $display("test ext_act done");
  endtask
  task automatic t_ext_en;
    i_cfg.security_disable = 1'b0;
    wr(1'b1, 4'h0, 16'h1200, 32'h0000_0003);
    rdc(1'b1, 4'h0, 16'h1200, 32'h0000_0001);
    wr(1'b0, 4'h0, 16'h1200, 32'h0000_0002);
    rdc(1'b0, 4'h0, 16'h1200, 32'h0000_0003);
    $display("test ext_en done");
  endtask
  task automatic t_norm;
    wr(1'b1, 4'h0, 16'h0104, 32'h0000_0003);
    chk(o_fwd_en[31:0], 32'h0000_0001);
    wr(1'b1, 4'h0, 16'h0108, 32'hffff_ffff);
    rdc(1'b0, 4'h0, 16'h0108, 32'h0);
    i_cfg.are_secure = 1'b0;
    i_cfg.are_nonsecure = 1'b0;
    rdc(1'b0, 4'h0, 16'h1a00, 32'h0);
    wr(1'b0, 4'h2, 16'h0100, 32'h0001_0000);
    wr(1'b0, 4'h9, 16'h0100, 32'h0002_0000);
    chk(o_fwd_en0[95:64], 32'h0001_0000);
    rdc(1'b0, 4'h9, 16'h0100, 32'h0);
    i_cfg.are_secure = 1'b1;
    i_cfg.are_nonsecure = 1'b1;
    rdc(1'b0, 4'h2, 16'h0100, 32'h0);
    i_cfg.security_disable = 1'b1;
    $display("test normal done");
  endtask
  task automatic t_reset;
    i_cfg.extended_range_supported = 1'b0;
    wr(1'b0, 4'h0, 16'h1200, 32'hffff_ffff);
    rdc(1'b0, 4'h0, 16'h1a00, 32'h0);
    i_cfg.extended_range_supported = 1'b1;
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    chk({31'h0, |{o_ext_en, o_ext_act}}, 32'h0);
    $display("test reset done");
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    t_ext_act();
    t_ext_en();
    t_norm();
    t_reset();
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge i_mclk);
    fail_count++;
    report_and_stop();
  end
endmodule
bind ise_set_banks ise_set_banks_sva u_ise_set_banks_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req),
  .i_cfg(i_cfg), .i_en_clr(i_en_clr), .i_ext_en_clr(i_ext_en_clr), .i_ext_act_clr(i_ext_act_clr),
  .o_rdata(o_rdata), .o_ack(o_ack), .o_fwd_en0(o_fwd_en0), .o_ext_en(o_ext_en), .o_ext_act(o_ext_act));
